// >>> shared/aivf_cfg.svh
// Offsets, codes, reset values and masks for the analog input value formatter
`ifndef AIVF_CFG_SVH
`define AIVF_CFG_SVH
`define AIVF_OFF_PRM0     8'h00
`define AIVF_OFF_PRM1     8'h04
`define AIVF_OFF_PRM2     8'h08
`define AIVF_OFF_PRM3     8'h0C
`define AIVF_OFF_REC0     8'h10
`define AIVF_OFF_RES_BASE 8'h20
`define AIVF_OFF_RES_LAST 8'h3C
`define AIVF_OFF_STAT     8'h40
`define AIVF_OFF_CJC      8'h44
`define AIVF_RST_PRM0     32'h1919AA00
`define AIVF_RST_PRM1     32'hFF7F1919
`define AIVF_RST_PRM2     32'hFF7F0080
`define AIVF_RST_PRM3     32'h00000080
`define AIVF_RST_REC0     16'h0000
`define AIVF_VAL_OVR      16'h7FFF
`define AIVF_VAL_UDR      16'h8000
`define AIVF_MASK_10HZ    16'hFFFE
`define AIVF_MASK_50HZ    16'hFFF8
`define AIVF_MASK_400HZ   16'hFFC0
`define AIVF_TYPE_OFF     8'h00
`define AIVF_TYPE_CUR4W   4'h2
`define AIVF_TYPE_CUR2W   4'h3
`define AIVF_TYPE_RES     4'h5
`define AIVF_TYPE_RTD     4'h6
`define AIVF_TYPE_TC_INT  4'h7
`define AIVF_TYPE_TC_EXT  4'h8
`define AIVF_TYPE_REFJ    4'h9
`define AIVF_RNG_4_20     4'h3
`define AIVF_BYTE_CTRL    0
`define AIVF_BYTE_SUPP    1
`define AIVF_BYTE_MODE0   2
`define AIVF_BYTE_UPL0    6
`define AIVF_BYTE_LOL0    8
`define AIVF_BYTE_UPL2    10
`define AIVF_BYTE_LOL2    12
`define AIVF_BIT_DIRQ_EN  6
`define AIVF_BIT_PIRQ_EN  7
`define AIVF_REC0_WB_LSB  8
`define AIVF_STAT_RNG_LSB 8
`define AIVF_STAT_LIM_LSB 16
`define AIVF_RESP_OKAY    2'h0
`define AIVF_RESP_SLVERR  2'h2
`endif

// >>> shared/aivf_pkg.sv
// Types shared by the analog input value formatter
package aivf_pkg;
	typedef enum logic [1:0] {
		AIVF_SUPP_400HZ = 2'h0,
		AIVF_SUPP_60HZ  = 2'h1,
		AIVF_SUPP_50HZ  = 2'h2,
		AIVF_SUPP_10HZ  = 2'h3
	} aivf_supp_e;

	typedef struct packed {
		logic        valid;
		logic [2:0]  chan;
		logic [15:0] value;
		logic        over;
		logic        under;
		logic        wire_break;
	} aivf_conv_s;

	typedef struct packed {
		logic [3:0][31:0] prm;
		logic [15:0]      rec0;
		logic [7:0][15:0] res;
		logic [7:0]       wbf;
		logic [7:0]       rngf;
		logic [1:0]       limf;
		logic [15:0]      cjc;
		logic [3:0]       cj_ext;
		logic             aw_got;
		logic             w_got;
		logic [7:0]       awa;
		logic [31:0]      wd;
		logic [3:0]       ws;
		logic             aw_rdy;
		logic             w_rdy;
		logic             bvalid;
		logic [1:0]       bresp;
		logic             ar_rdy;
		logic             rvalid;
		logic [1:0]       rresp;
		logic [31:0]      rdata;
		logic             fault;
		logic             dirq;
		logic             pirq;
	} aivf_state_s;
endpackage

// >>> hw/aivf_top.sv
// Analog input value formatter with AXI4-Lite register access
`include "aivf_cfg.svh"
module aivf_top (
	input  wire logic              clk_in,
	input  wire logic              rst_in,
	input  wire logic              ce_in,
	input  wire logic              two_ch_variant_in,
	input  wire aivf_pkg::aivf_conv_s conv_in,
	input  wire logic [7:0]        s_axi_awaddr_in,
	input  wire logic              s_axi_awvalid_in,
	output logic                   s_axi_awready_out,
	input  wire logic [31:0]       s_axi_wdata_in,
	input  wire logic [3:0]        s_axi_wstrb_in,
	input  wire logic              s_axi_wvalid_in,
	output logic                   s_axi_wready_out,
	output logic [1:0]             s_axi_bresp_out,
	output logic                   s_axi_bvalid_out,
	input  wire logic              s_axi_bready_in,
	input  wire logic [7:0]        s_axi_araddr_in,
	input  wire logic              s_axi_arvalid_in,
	output logic                   s_axi_arready_out,
	output logic [31:0]            s_axi_rdata_out,
	output logic [1:0]             s_axi_rresp_out,
	output logic                   s_axi_rvalid_out,
	input  wire logic              s_axi_rready_in,
	output logic [15:0]            cjc_ref_temp_out,
	output logic [3:0]             cj_use_ext_out,
	output logic                   group_fault_indicator_out,
	output logic                   diag_irq_out,
	output logic                   proc_irq_out
);
	import aivf_pkg::*;

	aivf_state_s s_q;
	aivf_state_s s_d;

	function automatic logic [7:0] prm_byte(input logic [3:0][31:0] p, input int k);
		logic [127:0] flat;
		flat = p;
		return flat[8*k +: 8];
	endfunction

	function automatic logic [15:0] prm_word(input logic [3:0][31:0] p, input int k);
		return {prm_byte(p, k), prm_byte(p, k + 1)};
	endfunction

	function automatic logic [15:0] fmt(input logic [15:0] v, input aivf_supp_e sp);
		logic [15:0] m;
		m = `AIVF_MASK_400HZ;
		unique case (sp)
			AIVF_SUPP_10HZ:                 m = `AIVF_MASK_10HZ;
			AIVF_SUPP_50HZ, AIVF_SUPP_60HZ: m = `AIVF_MASK_50HZ;
			AIVF_SUPP_400HZ:                m = `AIVF_MASK_400HZ;
		endcase
		// Sign bit always survives the mask
		return v & m;
	endfunction

	function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n,
			input logic [3:0] st);
		logic [31:0] r;
		r = o;
		for (int b = 0; b < 4; b++) begin
			if (st[b]) begin
				r[8*b +: 8] = n[8*b +: 8];
			end
		end
		return r;
	endfunction

	function automatic logic reg_hit(input logic [7:0] a);
		return (a <= `AIVF_OFF_CJC) && (a[1:0] == 2'h0);
	endfunction

	function automatic logic prm_bit(input logic [3:0][31:0] p, input int k, input int b);
		logic [7:0] by;
		by = prm_byte(p, k);
		return by[b];
	endfunction

	function automatic aivf_supp_e pair_supp(input logic [3:0][31:0] p, input logic [1:0] pr);
		logic [7:0] by;
		by = prm_byte(p, `AIVF_BYTE_SUPP);
		return aivf_supp_e'(by[2*pr +: 2]);
	endfunction

	function automatic logic [3:0] pair_type(input logic [3:0][31:0] p, input int pr);
		logic [7:0] by;
		by = prm_byte(p, `AIVF_BYTE_MODE0 + pr);
		return by[7:4];
	endfunction

	logic [1:0]  pair;
	logic [7:0]  mode;
	logic [3:0]  mtype;
	logic [3:0]  mrange;
	aivf_supp_e  supp;
	logic        pair_on;
	logic        two_wide;
	logic        is_temp;
	logic        wb_chk;
	logic        gd_en;
	logic [15:0] val;
	logic        wb_hit;
	logic        lim_hit;
	logic [2:0]  c0;
	logic [31:0] wclr;
	logic [7:0]  ridx;
	logic [31:0] rec_w;

	always_comb begin
		s_d      = s_q;
		pair     = conv_in.chan[2:1];
		mode     = prm_byte(s_q.prm, `AIVF_BYTE_MODE0 + int'(pair));
		mtype    = mode[7:4];
		mrange   = mode[3:0];
		supp     = pair_supp(s_q.prm, pair);
		// Pairs other than pair 0 on the narrow variant never run
		pair_on  = (mode != `AIVF_TYPE_OFF) && !(two_ch_variant_in && pair != 2'h0);
		two_wide = (mtype == `AIVF_TYPE_RES) || (mtype == `AIVF_TYPE_RTD)
			|| (mtype == `AIVF_TYPE_REFJ);
		is_temp  = (mtype == `AIVF_TYPE_RTD) || (mtype == `AIVF_TYPE_REFJ)
			|| (mtype == `AIVF_TYPE_TC_INT) || (mtype == `AIVF_TYPE_TC_EXT);
		wb_chk   = s_q.rec0[`AIVF_REC0_WB_LSB + pair];
		gd_en    = s_q.rec0[pair];
		wb_hit   = wb_chk && conv_in.wire_break
			&& (mtype == `AIVF_TYPE_CUR4W || mtype == `AIVF_TYPE_CUR2W)
			&& (mrange == `AIVF_RNG_4_20);
		if (conv_in.over) begin
			val = `AIVF_VAL_OVR;
		end else if (conv_in.under) begin
			val = `AIVF_VAL_UDR;
		end else if (is_temp) begin
			val = conv_in.value;
		end else begin
			val = fmt(conv_in.value, supp);
		end
		if (wb_hit) begin
			val = `AIVF_VAL_UDR;
		end
		if (mtype == `AIVF_TYPE_REFJ && conv_in.wire_break) begin
			val = `AIVF_VAL_OVR;
		end
		lim_hit = 1'b0;
		c0      = conv_in.chan;

		if (conv_in.valid && pair_on && !(two_wide && conv_in.chan[0])) begin
			// Whole word written at once so a read never mixes conversions
			s_d.res[c0] = val;
			if (two_wide) begin
				s_d.res[{c0[2:1], 1'b1}] = `AIVF_VAL_OVR;
			end
			if (mtype == `AIVF_TYPE_REFJ) begin
				s_d.cjc = val;
			end
			if (c0 == 3'h0 || c0 == 3'h2) begin
				lim_hit = ($signed(val) > $signed(prm_word(s_q.prm,
					c0[1] ? `AIVF_BYTE_UPL2 : `AIVF_BYTE_UPL0)))
					|| ($signed(val) < $signed(prm_word(s_q.prm,
					c0[1] ? `AIVF_BYTE_LOL2 : `AIVF_BYTE_LOL0)));
			end
		end

		for (int p = 0; p < 4; p++) begin
			// External thermocouples follow the reference junction except pairs 1 to 3 on the narrow variant, others their own sensor
			s_d.cj_ext[p] = (pair_type(s_q.prm, p) == `AIVF_TYPE_TC_EXT)
				&& !(two_ch_variant_in && p != 0);
		end

		// Write path: address and data may arrive in either order
		if (s_q.aw_rdy && s_axi_awvalid_in) begin
			s_d.aw_got = 1'b1;
			s_d.awa    = s_axi_awaddr_in;
		end
		if (s_q.w_rdy && s_axi_wvalid_in) begin
			s_d.w_got = 1'b1;
			s_d.wd    = s_axi_wdata_in;
			s_d.ws    = s_axi_wstrb_in;
		end
		rec_w = merge({16'h0, s_q.rec0}, s_q.wd, s_q.ws);
		wclr = 32'h0;
		if (s_q.aw_got && s_q.w_got && !s_q.bvalid) begin
			s_d.aw_got = 1'b0;
			s_d.w_got  = 1'b0;
			s_d.bvalid = 1'b1;
			s_d.bresp  = `AIVF_RESP_OKAY;
			unique case (s_q.awa)
				// The record is taken byte-wise into one sixteen-byte image
				`AIVF_OFF_PRM0: s_d.prm[0] = merge(s_q.prm[0], s_q.wd, s_q.ws);
				`AIVF_OFF_PRM1: s_d.prm[1] = merge(s_q.prm[1], s_q.wd, s_q.ws);
				`AIVF_OFF_PRM2: s_d.prm[2] = merge(s_q.prm[2], s_q.wd, s_q.ws);
				`AIVF_OFF_PRM3: s_d.prm[3] = merge(s_q.prm[3], s_q.wd, s_q.ws);
				`AIVF_OFF_REC0: s_d.rec0 = rec_w[15:0];
				`AIVF_OFF_STAT: wclr = merge(32'h0, s_q.wd, s_q.ws);
				default: begin
					if (!reg_hit(s_q.awa)) begin
						s_d.bresp = `AIVF_RESP_SLVERR;
					end
				end
			endcase
		end
		if (s_q.bvalid && s_axi_bready_in) begin
			s_d.bvalid = 1'b0;
		end
		s_d.aw_rdy = !s_d.aw_got && !s_d.bvalid;
		s_d.w_rdy  = !s_d.w_got && !s_d.bvalid;

		// Sticky flags: clear first so a same-cycle event wins
		s_d.wbf  = s_q.wbf & ~wclr[7:0];
		s_d.rngf = s_q.rngf & ~wclr[`AIVF_STAT_RNG_LSB +: 8];
		s_d.limf = s_q.limf & ~wclr[`AIVF_STAT_LIM_LSB +: 2];
		if (conv_in.valid && pair_on) begin
			if (wb_hit || (mtype == `AIVF_TYPE_REFJ && conv_in.wire_break && wb_chk)) begin
				s_d.wbf[c0] = 1'b1;
			end
			if (gd_en && (conv_in.over || conv_in.under)) begin
				s_d.rngf[c0] = 1'b1;
			end
			if (lim_hit && prm_bit(s_q.prm, `AIVF_BYTE_CTRL, `AIVF_BIT_PIRQ_EN)) begin
				s_d.limf[c0[1]] = 1'b1;
			end
		end
		s_d.fault = |s_d.wbf || |s_d.rngf;
		s_d.dirq  = prm_bit(s_d.prm, `AIVF_BYTE_CTRL, `AIVF_BIT_DIRQ_EN) && s_d.fault;
		s_d.pirq  = |s_d.limf;

		// Read path
		if (s_q.ar_rdy && s_axi_arvalid_in) begin
			s_d.ar_rdy = 1'b0;
			s_d.rvalid = 1'b1;
			s_d.rresp  = reg_hit(s_axi_araddr_in) ? `AIVF_RESP_OKAY : `AIVF_RESP_SLVERR;
			s_d.rdata  = 32'h0;
			ridx       = s_axi_araddr_in - `AIVF_OFF_RES_BASE;
			unique case (s_axi_araddr_in)
				`AIVF_OFF_PRM0: s_d.rdata = s_q.prm[0];
				`AIVF_OFF_PRM1: s_d.rdata = s_q.prm[1];
				`AIVF_OFF_PRM2: s_d.rdata = s_q.prm[2];
				`AIVF_OFF_PRM3: s_d.rdata = s_q.prm[3];
				`AIVF_OFF_REC0: s_d.rdata = {16'h0, s_q.rec0};
				`AIVF_OFF_STAT: s_d.rdata = {14'h0, s_q.limf, s_q.rngf, s_q.wbf};
				`AIVF_OFF_CJC:  s_d.rdata = {16'h0, s_q.cjc};
				default: begin
					if (s_axi_araddr_in >= `AIVF_OFF_RES_BASE
							&& s_axi_araddr_in <= `AIVF_OFF_RES_LAST) begin
						s_d.rdata = {16'h0, s_q.res[ridx[4:2]]};
					end
				end
			endcase
		end else begin
			ridx = 8'h0;
		end
		if (s_q.rvalid && s_axi_rready_in) begin
			s_d.rvalid = 1'b0;
			s_d.ar_rdy = 1'b1;
		end
	end

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			s_q        <= '0;
			s_q.prm[0] <= `AIVF_RST_PRM0;
			s_q.prm[1] <= `AIVF_RST_PRM1;
			s_q.prm[2] <= `AIVF_RST_PRM2;
			s_q.prm[3] <= `AIVF_RST_PRM3;
			s_q.rec0   <= `AIVF_RST_REC0;
			s_q.aw_rdy <= 1'b1;
			s_q.w_rdy  <= 1'b1;
			s_q.ar_rdy <= 1'b1;
		end else if (ce_in) begin
			s_q <= s_d;
		end
	end

	assign s_axi_awready_out         = s_q.aw_rdy;
	assign s_axi_wready_out          = s_q.w_rdy;
	assign s_axi_bvalid_out          = s_q.bvalid;
	assign s_axi_bresp_out           = s_q.bresp;
	assign s_axi_arready_out         = s_q.ar_rdy;
	assign s_axi_rvalid_out          = s_q.rvalid;
	assign s_axi_rresp_out           = s_q.rresp;
	assign s_axi_rdata_out           = s_q.rdata;
	assign cjc_ref_temp_out          = s_q.cjc;
	assign cj_use_ext_out            = s_q.cj_ext;
	assign group_fault_indicator_out = s_q.fault;
	assign diag_irq_out              = s_q.dirq;
	assign proc_irq_out              = s_q.pirq;

	default clocking cb @(posedge clk_in); endclocking
	default disable iff (rst_in);

	logic upd;
	assign upd = ce_in && conv_in.valid && pair_on && !(two_wide && conv_in.chan[0]);

	ovr_clamp_a: assert property (upd && conv_in.over && !is_temp
		&& mtype != `AIVF_TYPE_REFJ
		|=> s_q.res[$past(conv_in.chan)] == 16'h7FFF)
		else $error("overrange not clamped to 7FFF");
	udr_clamp_a: assert property (upd && conv_in.under && !conv_in.over && !wb_hit
		&& !(mtype == `AIVF_TYPE_REFJ && conv_in.wire_break)
		|=> s_q.res[$past(conv_in.chan)] == 16'h8000)
		else $error("underrange not clamped to 8000");
	// Clamped words carry their own fixed low bits, so 7FFF is left out of all three checks and 8000 out of the 50 Hz and 400 Hz ones
	mask_10hz_a: assert property (upd && !is_temp && !conv_in.over
		&& supp == AIVF_SUPP_10HZ
		|=> s_q.res[$past(conv_in.chan)][0] == 1'b0)
		else $error("10 Hz result bit 0 set");
	mask_50hz_a: assert property (upd && !is_temp && !conv_in.over && !conv_in.under
		&& !wb_hit && supp == AIVF_SUPP_50HZ
		|=> s_q.res[$past(conv_in.chan)][2:0] == 3'h0)
		else $error("50 Hz result low bits set");
	mask_400hz_a: assert property (upd && !is_temp && !conv_in.over && !conv_in.under
		&& !wb_hit && supp == AIVF_SUPP_400HZ
		|=> s_q.res[$past(conv_in.chan)][5:0] == 6'h0)
		else $error("400 Hz result low bits set");
	pair_second_a: assert property (upd && two_wide
		|=> s_q.res[{$past(conv_in.chan[2:1]), 1'b1}] == 16'h7FFF)
		else $error("second channel of wide pair not 7FFF");
	wire_break_a: assert property (upd && wb_hit
		|=> s_q.res[$past(conv_in.chan)] == 16'h8000 && s_q.wbf[$past(conv_in.chan)]
		##1 (group_fault_indicator_out || !ce_in))
		else $error("wire break not reported");
	off_pair_a: assert property (ce_in && conv_in.valid && !pair_on
		|=> $stable(s_q.res))
		else $error("inactive pair changed a result");
	diag_irq_a: assert property (diag_irq_out |-> group_fault_indicator_out)
		else $error("diagnostic interrupt without fault");
	dirq_gate_a: assert property (!prm_bit(s_q.prm, `AIVF_BYTE_CTRL, `AIVF_BIT_DIRQ_EN)
		|-> !diag_irq_out)
		else $error("diagnostic interrupt while disabled");
	sign_keep_a: assert property (upd && !is_temp && !conv_in.over && !conv_in.under
		&& !wb_hit
		|=> s_q.res[$past(conv_in.chan)][15] == $past(conv_in.value[15]))
		else $error("sign bit lost");
	temp_pass_a: assert property (upd && is_temp && !conv_in.over && !conv_in.under
		&& !conv_in.wire_break
		|=> s_q.res[$past(conv_in.chan)] == $past(conv_in.value))
		else $error("temperature result altered");
	refj_cjc_a: assert property (upd && mtype == `AIVF_TYPE_REFJ
		|=> cjc_ref_temp_out == s_q.res[$past(conv_in.chan)])
		else $error("reference temperature not forwarded");
	refj_break_a: assert property (upd && mtype == `AIVF_TYPE_REFJ && conv_in.wire_break
		|=> cjc_ref_temp_out == `AIVF_VAL_OVR)
		else $error("reference break not shown as 7FFF");
	range_flag_a: assert property (ce_in && conv_in.valid && pair_on && gd_en
		&& (conv_in.over || conv_in.under)
		|=> s_q.rngf[$past(conv_in.chan)])
		else $error("range flag not set");
	lim_chan_a: assert property (ce_in && conv_in.valid && conv_in.chan != 3'h0
		&& conv_in.chan != 3'h2
		|=> (s_q.limf & ~$past(s_q.limf)) == 2'h0)
		else $error("limit flag from other channel");
	narrow_pair_a: assert property (ce_in && two_ch_variant_in
		|=> cj_use_ext_out[3:1] == 3'h0)
		else $error("narrow variant used upper pair");
endmodule // aivf_top

// >>> dv/aivf_ctl_model.sv
// Controller-side AXI4-Lite master model that writes records and reads result words
module aivf_ctl_model (
	input  wire logic        clk_in,
	output logic [7:0]       awaddr_out,
	output logic             awvalid_out,
	input  wire logic        awready_in,
	output logic [31:0]      wdata_out,
	output logic [3:0]       wstrb_out,
	output logic             wvalid_out,
	input  wire logic        wready_in,
	input  wire logic [1:0]  bresp_in,
	input  wire logic        bvalid_in,
	output logic             bready_out,
	output logic [7:0]       araddr_out,
	output logic             arvalid_out,
	input  wire logic        arready_in,
	input  wire logic [31:0] rdata_in,
	input  wire logic [1:0]  rresp_in,
	input  wire logic        rvalid_in,
	output logic             rready_out
);
	timeunit 1ns;
	timeprecision 1ns;

	initial begin
		{awaddr_out, awvalid_out, wdata_out, wstrb_out, wvalid_out, bready_out} = '0;
		{araddr_out, arvalid_out, rready_out} = '0;
	end

	// Released address and data lines show the inverse so a stale value never looks valid; the write strobes stay at F
	task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		logic aw_done;
		logic w_done;
		aw_done = 1'b0;
		w_done = 1'b0;
		@(posedge clk_in);
		awaddr_out  <= a;
		wdata_out   <= d;
		wstrb_out   <= 4'hF;
		awvalid_out <= 1'b1;
		wvalid_out  <= 1'b1;
		bready_out  <= 1'b1;
		while (!(aw_done && w_done)) begin
			@(posedge clk_in);
			if (awvalid_out && awready_in) begin
				aw_done = 1'b1;
				awvalid_out <= 1'b0;
				awaddr_out  <= ~a;
			end
			if (wvalid_out && wready_in) begin
				w_done = 1'b1;
				wvalid_out <= 1'b0;
				wdata_out  <= ~d;
			end
		end
		do @(posedge clk_in); while (!bvalid_in);
		r = bresp_in;
		bready_out <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge clk_in);
		araddr_out  <= a;
		arvalid_out <= 1'b1;
		rready_out  <= 1'b1;
		do @(posedge clk_in); while (!arready_in);
		arvalid_out <= 1'b0;
		araddr_out  <= ~a;
		do @(posedge clk_in); while (!rvalid_in);
		d = rdata_in;
		r = rresp_in;
		rready_out <= 1'b0;
	endtask
endmodule // aivf_ctl_model

// >>> dv/test_analog_input_value_formatter.sv
// Self-checking bench for the analog input value formatter
module test_analog_input_value_formatter;
	timeunit 1ns;
	timeprecision 1ns;
	import aivf_pkg::*;
	logic        clk_in = 1'b0;
	logic        rst_in = 1'b1;
	logic        ce_in = 1'b1;
	logic        two_ch = 1'b0;
	aivf_conv_s  conv_q = '0;
	logic [7:0]  aw_a, ar_a;
	logic [31:0] w_d, r_d, rd_v;
	logic [3:0]  w_s, cj_ext;
	logic [1:0]  b_r, r_r, rsp;
	logic        aw_v, aw_r, w_v, w_r, b_v, b_y, ar_v, ar_r, r_v, r_y;
	logic [15:0] cjc_t;
	logic        fault, dirq, pirq;
	int          miscompares = 0;
	int          comparisons = 0;
	int          cycles = 0;

	aivf_top uut (
		.clk_in(clk_in), .rst_in(rst_in), .ce_in(ce_in), .two_ch_variant_in(two_ch),
		.conv_in(conv_q), .s_axi_awaddr_in(aw_a), .s_axi_awvalid_in(aw_v),
		.s_axi_awready_out(aw_r), .s_axi_wdata_in(w_d), .s_axi_wstrb_in(w_s),
		.s_axi_wvalid_in(w_v), .s_axi_wready_out(w_r), .s_axi_bresp_out(b_r),
		.s_axi_bvalid_out(b_v), .s_axi_bready_in(b_y), .s_axi_araddr_in(ar_a),
		.s_axi_arvalid_in(ar_v), .s_axi_arready_out(ar_r), .s_axi_rdata_out(r_d),
		.s_axi_rresp_out(r_r), .s_axi_rvalid_out(r_v), .s_axi_rready_in(r_y),
		.cjc_ref_temp_out(cjc_t), .cj_use_ext_out(cj_ext),
		.group_fault_indicator_out(fault), .diag_irq_out(dirq), .proc_irq_out(pirq)
	);
	aivf_ctl_model ctl (
		.clk_in(clk_in), .awaddr_out(aw_a), .awvalid_out(aw_v), .awready_in(aw_r),
		.wdata_out(w_d), .wstrb_out(w_s), .wvalid_out(w_v), .wready_in(w_r),
		.bresp_in(b_r), .bvalid_in(b_v), .bready_out(b_y), .araddr_out(ar_a),
		.arvalid_out(ar_v), .arready_in(ar_r), .rdata_in(r_d), .rresp_in(r_r),
		.rvalid_in(r_v), .rready_out(r_y)
	);

	always #20 clk_in = ~clk_in;

	// The whole sequence needs well under a thousand cycles
	always @(posedge clk_in) begin
		cycles <= cycles + 1;
		if (cycles == 5000) begin
			miscompares++;
			stop_test();
		end
	end

	task automatic stop_test;
		$display("comparisons %0d miscompares %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		comparisons++;
		if (g !== e) begin
			miscompares++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] e);
		ctl.rd(a, rd_v, rsp);
		chk(nm, e, rd_v);
	endtask

	// Flags f: over, under, wire break
	task automatic conv(input logic [2:0] ch, input logic [15:0] v, input logic [2:0] f);
		@(posedge clk_in);
		conv_q <= '{1'b1, ch, v, f[2], f[1], f[0]};
		@(posedge clk_in);
		conv_q <= '{1'b0, ch, ~v, 1'b0, 1'b0, 1'b0};
	endtask

	task automatic t_reset;
		rdc("prm0", 8'h00, 32'h1919AA00);
		rdc("prm1", 8'h04, 32'hFF7F1919);
		rdc("prm2", 8'h08, 32'hFF7F0080);
		rdc("prm3", 8'h0C, 32'h00000080);
		rdc("rec0", 8'h10, 32'h0);
		ctl.rd(8'h80, rd_v, rsp);
		chk("unmapped resp", 2'h2, rsp);
		ctl.wr(8'h80, 32'h0, rsp);
		chk("unmapped wr resp", 2'h2, rsp);
		ctl.wr(8'h20, 32'h1234, rsp);
		chk("ro wr resp", 2'h0, rsp);
		rdc("ro result", 8'h20, 32'h0);
		chk("fault idle", 1'b0, fault);
	endtask

	task automatic t_mask;
		logic [15:0] m [4] = '{16'hFFC0, 16'hFFF8, 16'hFFF8, 16'hFFFE};
		for (int s = 0; s < 4; s++) begin
			ctl.wr(8'h00, {16'h1919, 8'hA8 | 8'(s), 8'h00}, rsp);
			conv(3'd0, 16'hB6DB, 3'b000);
			rdc("masked res0", 8'h20, {16'h0, 16'hB6DB & m[s]});
		end
	endtask

	task automatic t_clamp;
		conv(3'd1, 16'h1238, 3'b100);
		rdc("over res1", 8'h24, 32'h7FFF);
		conv(3'd1, 16'h1238, 3'b010);
		rdc("under res1", 8'h24, 32'h8000);
		chk("no group diag", 1'b0, fault);
	endtask

	task automatic t_pairs;
		ctl.wr(8'h00, 32'h8019AA00, rsp);
		ctl.wr(8'h04, 32'hFF7F9050, rsp);
		conv(3'd6, 16'h0105, 3'b000);
		conv(3'd7, 16'h1111, 3'b000);
		conv(3'd4, 16'h1235, 3'b000);
		conv(3'd5, 16'h2222, 3'b000);
		conv(3'd2, 16'h0123, 3'b000);
		rdc("refj res6", 8'h38, 32'h0105);
		rdc("refj res7", 8'h3C, 32'h7FFF);
		rdc("res res4", 8'h30, 32'h1230);
		rdc("res res5", 8'h34, 32'h7FFF);
		rdc("tc res2", 8'h28, 32'h0123);
		chk("cjc temp", 16'h0105, cjc_t);
		chk("ext comp", 4'h2, cj_ext);
		conv(3'd6, 16'h0105, 3'b001);
		rdc("refj break", 8'h38, 32'h7FFF);
		rdc("cjc reg", 8'h44, 32'h7FFF);
		chk("cjc break", 16'h7FFF, cjc_t);
		ctl.wr(8'h00, 32'h7019AA00, rsp);
		rdc("prm0 tc int", 8'h00, 32'h7019AA00);
		chk("int comp", 4'h0, cj_ext);
		ctl.wr(8'h00, 32'h0019AA00, rsp);
		conv(3'd2, 16'h4444, 3'b000);
		rdc("off res2", 8'h28, 32'h0123);
	endtask

	task automatic t_wb;
		ctl.wr(8'h10, 32'h0101, rsp);
		ctl.wr(8'h00, 32'h0023AA00, rsp);
		conv(3'd0, 16'h0123, 3'b001);
		rdc("break res0", 8'h20, 32'h8000);
		ctl.rd(8'h40, rd_v, rsp);
		chk("break flag", 1'b1, rd_v[0]);
		chk("fault on", 1'b1, fault);
		chk("dirq masked", 1'b0, dirq);
		ctl.wr(8'h00, 32'h0023AA40, rsp);
		rdc("prm0 dirq", 8'h00, 32'h0023AA40);
		chk("dirq on", 1'b1, dirq);
		ctl.wr(8'h40, 32'hFFFFFFFF, rsp);
		rdc("status clear", 8'h40, 32'h0);
		chk("fault off", 1'b0, fault);
		conv(3'd0, 16'h0123, 3'b100);
		rdc("range res0", 8'h20, 32'h7FFF);
		chk("range fault", 1'b1, fault);
		ctl.wr(8'h10, 32'h0, rsp);
		ctl.wr(8'h40, 32'hFFFFFFFF, rsp);
	endtask

	task automatic t_limit;
		ctl.wr(8'h04, 32'h00109050, rsp);
		ctl.wr(8'h0C, 32'h00000001, rsp);
		ctl.wr(8'h00, 32'h1919AA80, rsp);
		conv(3'd1, 16'h2000, 3'b000);
		rdc("res1", 8'h24, 32'h2000);
		chk("no limit ch1", 1'b0, pirq);
		conv(3'd0, 16'h2000, 3'b000);
		rdc("res0", 8'h20, 32'h2000);
		chk("limit ch0", 1'b1, pirq);
		conv(3'd2, 16'h0008, 3'b000);
		ctl.rd(8'h40, rd_v, rsp);
		chk("limit flags", 2'h3, rd_v[17:16]);
		ctl.wr(8'h40, 32'hFFFFFFFF, rsp);
		rdc("limit clear", 8'h40, 32'h0);
		chk("pirq off", 1'b0, pirq);
	endtask

	task automatic t_two;
		two_ch <= 1'b1;
		ctl.wr(8'h00, 32'h8080AA00, rsp);
		ctl.rd(8'h00, rd_v, rsp);
		chk("two ch ext", 4'h1, cj_ext);
		conv(3'd2, 16'h5555, 3'b000);
		rdc("two ch res2", 8'h28, 32'h0008);
		conv(3'd0, 16'h0246, 3'b000);
		rdc("two ch res0", 8'h20, 32'h0246);
		two_ch <= 1'b0;
	endtask

	initial begin
		repeat (16) @(posedge clk_in);
		rst_in <= 1'b0;
		t_reset();
		t_mask();
		t_clamp();
		t_pairs();
		t_wb();
		t_limit();
		t_two();
		stop_test();
	end
endmodule // test_analog_input_value_formatter
